// ### rtl/modbus_pkg.sv
// ==========================================================================
// Shared constants for the serial register server.
// ==========================================================================
package modbus_pkg;

  // ========================================================================
  // Function codes and exception codes.
  // ========================================================================
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;

  // ========================================================================
  // Frame layout and checksum.
  // ========================================================================
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [3:0] REQ_LEN = 4'h8;
  localparam logic [3:0] MIN_LEN = 4'h4;
  localparam logic [3:0] LEN_SAT = 4'hF;
  localparam logic [7:0] HDR_LEN = 8'h03;
  localparam logic [7:0] ECHO_LEN = 8'h06;
  localparam logic [15:0] RD_QTY_MAX = 16'h007D;
  localparam logic [1:0] PH_DATA = 2'h0;
  localparam logic [1:0] PH_CRC_LO = 2'h1;
  localparam logic [1:0] PH_CRC_HI = 2'h2;

  // ========================================================================
  // Data sets, write window.
  // ========================================================================
  localparam int NUM_SETS = 3;
  localparam logic [1:0] SET_STD = 2'h0;
  localparam logic [1:0] SET_SCAN = 2'h1;
  localparam logic [1:0] SET_CAPS = 2'h2;
  localparam int IDX_SLOT = 0;
  localparam logic [15:0] WR_BASE = 16'h0100;
  localparam logic [15:0] WR_WORDS = 16'h0010;

  // ========================================================================
  // Timing.
  // ========================================================================
  localparam int CLK_HZ = 10_000_000;
  localparam int RESP_MS = 200;
  localparam int REPEAT_MS = 1000;
  localparam int SILENCE_US = 4010;
  localparam int RESP_CYC = CLK_HZ / 1000 * RESP_MS;
  localparam int REPEAT_CYC = CLK_HZ / 1000 * REPEAT_MS;
  localparam int SILENCE_CYC = (CLK_HZ / 1_000_000) * SILENCE_US;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT_WR = 3'b011,
    ST_SEND = 3'b100
  } state_e;

endpackage

// ### rtl/modbus_rtu_measurement_slave.sv
`timescale 1ns/1ps

// ==========================================================================
// Byte FIFO between the reply generator and the line transmitter.
// ==========================================================================
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}}
                                                 : (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic push;
  logic pop;

  assign in_ready = q.cnt != FULL;
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at DEPTH so non-power-of-two depths also work.
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop)
    begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage, pointers and count clear on reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule // reply_fifo

// ==========================================================================
// Serial register server front end.
// ==========================================================================
// Summary of operation
// - Only a slave: nothing is sent except as the reply to a master frame.
// - A repeated write to the same register may take up to 1 s to answer.
// - Each channel holds a standard, a scan and a capacitance data set.
// - Each set has an index that counts up once per committed measurement.
// - Values sent in one reply with an index all belong to one measurement.
// - Registers are 16 bits and are sent high byte first.
// - 32-bit values take two registers, low word first, bytes big-endian.
// - Floats are IEEE 754 single precision, split across two registers.
// - Byte swap exchanges the bytes in each word, word order and CRC kept.
// - Exceptions 01, 02, 03 flag bad function, address and data value.
// - Exception 06 is returned to a write while a long command keeps the unit busy.
module modbus_rtu_measurement_slave #(
  parameter int CHANNELS = 2,
  parameter int SLOTS = 4,
  parameter int FIFO_DEPTH = 32,
  parameter int SILENCE_CYCLES = modbus_pkg::SILENCE_CYC,
  parameter int RESP_CYCLES = modbus_pkg::RESP_CYC,
  parameter int REPEAT_CYCLES = modbus_pkg::REPEAT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] slave_addr,
  input wire logic byte_swap,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  input wire logic meas_we,
  input wire logic [$clog2(CHANNELS)-1:0] meas_chan,
  input wire logic [1:0] meas_set,
  input wire logic [$clog2(SLOTS)-1:0] meas_slot,
  input wire logic [31:0] meas_data,
  input wire logic meas_commit,
  input wire logic dev_busy,
  output logic wr_valid,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  input wire logic wr_ack
);
  localparam int NSETS = CHANNELS * modbus_pkg::NUM_SETS;
  localparam int NENT = NSETS * SLOTS;
  localparam logic [16:0] TOTAL_REGS = 17'(2 * NENT);
  localparam int IDX_SLOT = modbus_pkg::IDX_SLOT;

  typedef struct packed {
    modbus_pkg::state_e st;
    logic [3:0] rx_cnt;
    logic [7:0][7:0] rbuf;
    logic [15:0] crc;
    logic [31:0] tmr;
    logic [31:0] lim;
    logic [7:0] code;
    logic [7:0] len;
    logic [7:0] idx;
    logic [1:0] ph;
    logic [15:0] last_wr;
    logic last_ok;
    logic [NSETS-1:0] pend;
    logic [NENT-1:0][31:0] live;
    logic [NENT-1:0][31:0] shadow;
  } slave_s;

  slave_s q;
  slave_s d;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] tx_byte;
  logic [7:0] fc;
  logic [15:0] start;
  logic [15:0] value;
  logic [15:0] rd_reg;
  logic [15:0] rd_word;
  logic [7:0] rd_off;
  logic hi_first;
  logic is_write;
  int set_id;

  // One step of the reflected CRC-16 used on the serial line.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ modbus_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  assign fc = q.rbuf[1];
  assign start = {q.rbuf[2], q.rbuf[3]};
  assign value = {q.rbuf[4], q.rbuf[5]};
  assign is_write = fc == modbus_pkg::FC_WR_SINGLE;
  assign wr_valid = q.st == modbus_pkg::ST_WAIT_WR;
  assign wr_addr = start;
  assign wr_data = value;
  // A set code past the last set maps out of range and is ignored.
  assign set_id = (int'(meas_set) < modbus_pkg::NUM_SETS) ?
                  int'(meas_chan) * modbus_pkg::NUM_SETS + int'(meas_set) :
                  NSETS;

  // Reply byte selection; data bytes come from the frozen live copy.
  always_comb
  begin
    rd_off = q.idx - modbus_pkg::HDR_LEN;
    rd_reg = start + 16'(rd_off[7:1]);
    rd_word = rd_reg[0] ? q.live[rd_reg[15:1]][31:16]
                        : q.live[rd_reg[15:1]][15:0];
    hi_first = !rd_off[0] ^ byte_swap;
    tx_byte = 8'h00;
    if (q.ph == modbus_pkg::PH_CRC_LO)
      tx_byte = q.crc[7:0];
    else if (q.ph == modbus_pkg::PH_CRC_HI)
      tx_byte = q.crc[15:8];
    else if (q.idx == 8'h00)
      tx_byte = slave_addr;
    else if (q.idx == 8'h01)
      tx_byte = (q.code != modbus_pkg::EXC_NONE) ?
                (fc | modbus_pkg::EXC_FLAG) : fc;
    else if (q.code != modbus_pkg::EXC_NONE)
      tx_byte = q.code;
    else if (is_write)
      tx_byte = q.rbuf[q.idx[2:0]];
    else if (q.idx == 8'h02)
      tx_byte = q.len - modbus_pkg::HDR_LEN;
    else
      tx_byte = hi_first ? rd_word[15:8] : rd_word[7:0];
  end

  // Frame receive, decode, write hand-off and reply sequencing.
  always_comb
  begin
    d = q;
    fifo_in_valid = 1'b0;
    if (meas_we && meas_slot != '0 && set_id < NSETS)
      d.shadow[set_id * SLOTS + int'(meas_slot)] = meas_data;
    case (q.st)
      modbus_pkg::ST_IDLE, modbus_pkg::ST_RX:
      begin
        if (rx_valid)
        begin
          // replies only follow a master frame
          d.st = modbus_pkg::ST_RX;
          d.tmr = '0;
          d.crc = crc_byte(q.st == modbus_pkg::ST_IDLE ?
                           modbus_pkg::CRC_INIT : q.crc, rx_data);
          d.rx_cnt = (q.st == modbus_pkg::ST_IDLE) ? 4'h1 :
                     (q.rx_cnt == modbus_pkg::LEN_SAT) ? q.rx_cnt :
                     q.rx_cnt + 4'h1;
          if (q.st == modbus_pkg::ST_IDLE)
            d.rbuf[0] = rx_data;
          else if (q.rx_cnt < modbus_pkg::REQ_LEN)
            d.rbuf[q.rx_cnt[2:0]] = rx_data;
        end
        else if (q.st == modbus_pkg::ST_RX)
        begin
          d.tmr = q.tmr + 32'h1;
          if (q.tmr == 32'(SILENCE_CYCLES - 1))
          begin
            // drop bad CRC and foreign frames
            if (q.crc == modbus_pkg::CRC_RESIDUE &&
                q.rbuf[0] == slave_addr &&
                q.rx_cnt >= modbus_pkg::MIN_LEN)
              d.st = modbus_pkg::ST_EXEC;
            else
              d.st = modbus_pkg::ST_IDLE;
          end
        end
      end
      modbus_pkg::ST_EXEC:
      begin
        d.st = modbus_pkg::ST_SEND;
        d.crc = modbus_pkg::CRC_INIT;
        d.idx = '0;
        d.ph = modbus_pkg::PH_DATA;
        d.code = modbus_pkg::EXC_NONE;
        d.len = modbus_pkg::HDR_LEN;
        if (fc == modbus_pkg::FC_RD_HOLD || fc == modbus_pkg::FC_RD_INPUT)
        begin
          if (q.rx_cnt != modbus_pkg::REQ_LEN || value == 16'h0000 ||
              value > modbus_pkg::RD_QTY_MAX)
            d.code = modbus_pkg::EXC_VALUE;
          else if ({1'b0, start} + {1'b0, value} > TOTAL_REGS)
            d.code = modbus_pkg::EXC_ADDR;
          else
            d.len = modbus_pkg::HDR_LEN + {value[6:0], 1'b0};
        end
        else if (is_write)
        begin
          if (q.rx_cnt != modbus_pkg::REQ_LEN)
            d.code = modbus_pkg::EXC_VALUE;
          else if (start < modbus_pkg::WR_BASE ||
                   start >= modbus_pkg::WR_BASE + modbus_pkg::WR_WORDS)
            d.code = modbus_pkg::EXC_ADDR;
          else if (dev_busy)
            d.code = modbus_pkg::EXC_BUSY;
          else
          begin
            d.st = modbus_pkg::ST_WAIT_WR;
            d.tmr = '0;
            // repeated write gets the long limit
            // otherwise the short limit
            // Half the limit is kept back for sending the reply itself.
            d.lim = (q.last_ok && q.last_wr == start) ?
                    32'(REPEAT_CYCLES / 2) : 32'(RESP_CYCLES / 2);
            d.last_wr = start;
            d.last_ok = 1'b1;
          end
        end
        else
          d.code = modbus_pkg::EXC_FUNC;
      end
      modbus_pkg::ST_WAIT_WR:
      begin
        d.tmr = q.tmr + 32'h1;
        if (wr_ack)
        begin
          d.st = modbus_pkg::ST_SEND;
          d.len = modbus_pkg::ECHO_LEN;
        end
        // a stalled write turns into a busy reply
        else if (q.tmr >= q.lim)
        begin
          d.st = modbus_pkg::ST_SEND;
          d.code = modbus_pkg::EXC_BUSY;
        end
      end
      modbus_pkg::ST_SEND:
      begin
        fifo_in_valid = 1'b1;
        if (fifo_in_ready)
        begin
          d.crc = crc_byte(q.crc, tx_byte);
          if (q.ph == modbus_pkg::PH_DATA)
          begin
            if (q.idx == q.len - 8'h01)
              d.ph = modbus_pkg::PH_CRC_LO;
            else
              d.idx = q.idx + 8'h01;
          end
          else if (q.ph == modbus_pkg::PH_CRC_LO)
          begin
            d.crc = q.crc;
            d.ph = modbus_pkg::PH_CRC_HI;
          end
          else
            d.st = modbus_pkg::ST_IDLE;
        end
      end
      default:
        d.st = modbus_pkg::ST_IDLE;
    endcase
    if (meas_commit && set_id < NSETS)
      d.pend[set_id] = 1'b1;
    // sets are republished only between replies
    if (q.st != modbus_pkg::ST_SEND)
    begin
      for (int s = 0; s < NSETS; s++)
      begin
        if (d.pend[s])
        begin
          d.pend[s] = 1'b0;
          d.live[s * SLOTS + IDX_SLOT] = q.live[s * SLOTS + IDX_SLOT] + 32'h1;
          // float bit patterns are copied unchanged
          for (int k = 1; k < SLOTS; k++)
            d.live[s * SLOTS + k] = d.shadow[s * SLOTS + k];
        end
      end
    end
  end

  // State register; reset clears every set, index and pending commit.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  // Reply bytes queue here so a slow transmitter stalls the generator.
  reply_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(tx_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule // modbus_rtu_measurement_slave

// ### dv/modbus_line_master.sv
`timescale 1ns/1ps

// ==========================================================================
// Line-side model of the polling bus master.
// ==========================================================================
module modbus_line_master (
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  // Idle line with the reader stalled.
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // Reflected checksum; the low byte goes on the line first.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = modbus_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ modbus_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // master starts, one frame, checksum appended.
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    // The idle byte is inverted so a stale value is never re-read.
    rx_data <= ~q[q.size()-1];
  endtask

  // Slow reader: ready toggles so the server must hold each byte.
  task automatic recv(input int n, output logic [7:0] got[$]);
    int guard;
    got = {};
    guard = 0;
    while (got.size() < n && guard < 2000)
    begin
      @(negedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        got.push_back(tx_data);
      @(posedge clk);
      tx_ready <= (got.size() < n) ? ~tx_ready : 1'b0;
      guard++;
    end
  endtask
endmodule // modbus_line_master

// ### dv/modbus_rtu_measurement_slave_chk.sv
`timescale 1ns/1ps

// ==========================================================================
// Port checks for the serial register server.
// ==========================================================================
module modbus_rtu_measurement_slave_chk #(
  parameter int SILENCE_CYCLES = modbus_pkg::SILENCE_CYC,
  parameter int REPEAT_CYCLES = modbus_pkg::REPEAT_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic dev_busy,
  input wire logic wr_valid,
  input wire logic [15:0] wr_addr,
  input wire logic wr_ack
);
  logic [31:0] quiet_q;
  logic [31:0] wr_len_q;

  // Quiet line time since the last request byte, and write wait length.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      quiet_q <= 32'h00000000;
      wr_len_q <= 32'h00000000;
    end
    else
    begin
      quiet_q <= rx_valid ? 32'h00000000 :
        ((&quiet_q) ? quiet_q : quiet_q + 32'h1);
      wr_len_q <= wr_valid ? wr_len_q + 32'h1 : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_tx_byte_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Reply byte changed while stalled.");
  a_wr_req_held: assert property (
    wr_valid && !wr_ack |=> !wr_valid || $stable(wr_addr))
    else $error("Write address moved while waiting.");
  a_wr_in_window: assert property (
    wr_valid |-> wr_addr >= modbus_pkg::WR_BASE &&
      wr_addr < modbus_pkg::WR_BASE + modbus_pkg::WR_WORDS)
    else $error("Write issued outside the window.");
  a_wr_wait_bound: assert property (
    wr_valid |-> wr_len_q <= 32'(REPEAT_CYCLES / 2 + 2))
    else $error("Write wait exceeded the long limit.");
  a_tx_after_frame: assert property (
    $rose(tx_valid) |-> quiet_q >= 32'(SILENCE_CYCLES))
    else $error("Reply began before the frame gap.");
  a_wr_after_frame: assert property (
    $rose(wr_valid) |-> quiet_q >= 32'(SILENCE_CYCLES))
    else $error("Write began before the frame gap.");
  a_wr_no_reply: assert property (
    wr_valid |-> !tx_valid)
    else $error("Reply bytes during a pending write.");
  a_busy_no_wr: assert property (
    $rose(wr_valid) |-> !$past(dev_busy))
    else $error("Write issued while the unit was busy.");
  a_ack_reply: assert property (
    wr_valid && wr_ack |-> ##[1:6] tx_valid)
    else $error("No echo soon after the write ack.");
endmodule // modbus_rtu_measurement_slave_chk

bind modbus_rtu_measurement_slave modbus_rtu_measurement_slave_chk #(
  .SILENCE_CYCLES(SILENCE_CYCLES),
  .REPEAT_CYCLES(REPEAT_CYCLES)
) u_chk (
  .clk(clk),
  .arst_n(arst_n),
  .rx_valid(rx_valid),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .tx_data(tx_data),
  .dev_busy(dev_busy),
  .wr_valid(wr_valid),
  .wr_addr(wr_addr),
  .wr_ack(wr_ack)
);

// ### dv/modbus_rtu_measurement_slave_tb.sv
`timescale 1ns/1ps

// ==========================================================================
// Self-checking bench for the serial register server.
// ==========================================================================
module modbus_rtu_measurement_slave_tb;
  localparam int SIL = 16;
  localparam int RESP = 200;
  localparam int REP = 1000;
  localparam logic [7:0] ADDR = 8'h11;
  logic clk, arst_n, byte_swap, rx_valid, tx_valid, tx_ready, meas_we;
  logic meas_commit, dev_busy, wr_valid, wr_ack, meas_chan;
  logic [7:0] rx_data, tx_data;
  logic [1:0] meas_set, meas_slot;
  logic [31:0] meas_data;
  logic [15:0] wr_addr, wr_data;
  logic [31:0] idx_exp[6];
  logic [31:0] val_exp[6];
  int bad_count = 0;
  int num_checks = 0;

  modbus_rtu_measurement_slave #(
    .SILENCE_CYCLES(SIL),
    .RESP_CYCLES(RESP),
    .REPEAT_CYCLES(REP)
  ) u_dut (
    .clk(clk), .arst_n(arst_n), .slave_addr(ADDR), .byte_swap(byte_swap),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .meas_we(meas_we),
    .meas_chan(meas_chan), .meas_set(meas_set), .meas_slot(meas_slot),
    .meas_data(meas_data), .meas_commit(meas_commit),
    .dev_busy(dev_busy), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ack(wr_ack)
  );

  modbus_line_master u_mst (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data)
  );

  // 100 ns clock.
  always #50 clk = ~clk;

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A 32-bit value goes out low word first, each word high byte first, or low byte first when sw is set.
  task automatic put32(ref logic [7:0] q[$], input logic [31:0] v,
                       input logic sw);
    q.push_back(sw ? v[7:0] : v[15:8]);
    q.push_back(sw ? v[15:8] : v[7:0]);
    q.push_back(sw ? v[23:16] : v[31:24]);
    q.push_back(sw ? v[31:24] : v[23:16]);
  endtask

  // Send one request, then compare the whole reply with its checksum.
  task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$]);
    logic [7:0] got[$];
    logic [15:0] c;
    u_mst.send(req, 1'b0);
    c = u_mst.crc16(exp);
    exp.push_back(c[7:0]);
    exp.push_back(c[15:8]);
    u_mst.recv(exp.size(), got);
    chk(16'(got.size()), 16'(exp.size()));
    foreach (got[i])
      chk({8'h00, got[i]}, {8'h00, exp[i]});
  endtask

  // A dropped frame must leave both outputs idle.
  task automatic quiet(input logic [7:0] req[$], input logic bad);
    u_mst.send(req, bad);
    repeat (SIL + 40)
    begin
      @(negedge clk);
      chk({14'h0000, tx_valid, wr_valid}, 16'h0000);
    end
  endtask

  // Publish one value per set; it shows only once committed.
  task automatic t_sets(input logic sw);
    logic [7:0] e[$];
    logic [7:0] fc;
    logic [15:0] a;
    logic [31:0] v;
    for (int n = 0; n < 6; n++)
    begin
      a = 16'(n * 8);
      fc = n[0] ? modbus_pkg::FC_RD_HOLD : modbus_pkg::FC_RD_INPUT;
      v = 32'h42C25E8D + 32'(n) + {27'h0, sw, 4'h0};
      @(posedge clk);
      byte_swap <= sw;
      meas_chan <= 1'(n / 3);
      meas_set <= 2'(n % 3);
      meas_slot <= 2'h1;
      meas_data <= v;
      meas_we <= 1'b1;
      @(posedge clk);
      meas_we <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
        e = {ADDR, fc, 8'h08};
        put32(e, idx_exp[n], sw);
        put32(e, val_exp[n], sw);
        xact({ADDR, fc, a[15:8], a[7:0], 8'h00, 8'h04}, e);
        // One commit pulse, so the index steps exactly once.
        @(posedge clk);
        meas_commit <= (k == 0);
        @(posedge clk);
        meas_commit <= 1'b0;
        idx_exp[n] = idx_exp[n] + 32'(k == 0);
        val_exp[n] = v;
      end
    end
  endtask

  // Refused requests, boundary addresses and dropped frames.
  task automatic t_exc();
    xact({ADDR, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01},
         {ADDR, 8'h85, 8'h01});
    xact({ADDR, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00},
         {ADDR, 8'h84, 8'h03});
    xact({ADDR, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7E},
         {ADDR, 8'h83, 8'h03});
    xact({ADDR, 8'h04, 8'h00, 8'h00}, {ADDR, 8'h84, 8'h03});
    xact({ADDR, 8'h04, 8'h00, 8'h2F, 8'h00, 8'h02},
         {ADDR, 8'h84, 8'h02});
    xact({ADDR, 8'h06, 8'h00, 8'hFF, 8'h00, 8'h01},
         {ADDR, 8'h86, 8'h02});
    xact({ADDR, 8'h04, 8'h00, 8'h2F, 8'h00, 8'h01},
         {ADDR, 8'h04, 8'h02, 8'h00, 8'h00});
    quiet({ADDR, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
    quiet({8'h12, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
  endtask

  // Wait for the write request, check it, then ack or time its timeout.
  task automatic wr_side(input logic [15:0] a, input logic [15:0] d,
                         input int lim);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < SIL + 60)
    begin
      @(negedge clk);
      n++;
    end
    chk(wr_addr, a);
    chk(wr_data, d);
    n = 0;
    if (lim == 0)
    begin
      @(posedge clk);
      wr_ack <= 1'b1;
      @(posedge clk);
      wr_ack <= 1'b0;
    end
    else
    begin
      while (wr_valid === 1'b1 && n < REP)
      begin
        @(negedge clk);
        n++;
      end
      chk(16'(n >= lim - 2 && n <= lim + 2), 16'h0001);
    end
  endtask

  // Acked write, repeated write, fresh write and busy refusal.
  task automatic t_write();
    logic [7:0] busy[$];
    busy = {ADDR, 8'h86, modbus_pkg::EXC_BUSY};
    fork
      xact({ADDR, 8'h06, 8'h01, 8'h00, 8'hBE, 8'hEF},
           {ADDR, 8'h06, 8'h01, 8'h00, 8'hBE, 8'hEF});
      wr_side(16'h0100, 16'hBEEF, 0);
    join
    fork
      xact({ADDR, 8'h06, 8'h01, 8'h00, 8'h12, 8'h34}, busy);
      wr_side(16'h0100, 16'h1234, REP / 2);
    join
    fork
      xact({ADDR, 8'h06, 8'h01, 8'h0F, 8'h56, 8'h78}, busy);
      wr_side(16'h010F, 16'h5678, RESP / 2);
    join
    @(posedge clk);
    dev_busy <= 1'b1;
    xact({ADDR, 8'h06, 8'h01, 8'h01, 8'h00, 8'h01}, busy);
    @(posedge clk);
    dev_busy <= 1'b0;
  endtask

  // Cut a hang short after far more than the tests need.
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    {byte_swap, meas_we, meas_commit, dev_busy, wr_ack, meas_chan} = '0;
    meas_set = 2'h0;
    meas_slot = 2'h0;
    meas_data = 32'h00000000;
    foreach (idx_exp[i])
    begin
      idx_exp[i] = 32'h00000000;
      val_exp[i] = 32'h00000000;
    end
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_sets(1'b0);
    t_sets(1'b1);
    @(posedge clk);
    byte_swap <= 1'b0;
    t_exc();
    t_write();
    final_report();
  end
endmodule // modbus_rtu_measurement_slave_tb
